// ---- src/video_switch_control_regs.sv ----
`timescale 1ns/1ps
`include "video_switch_cfg.svh"

// Function
// [R1] irq rises for a status change; drops once the host has read status.
// [R2] status register returns live conditions on every read.
// [R3] power mode: 00 normal, 01 standby, 10 or 11 deep sleep.
// [R4] automatic selection picks the port from cable power sense and priority.
// [R5] with automatic selection off the manual port field chooses the port.
// [R6] host reads status after toggling automatic selection to learn the port.
// [R7] priority field 00..11 names ports 1..4.
// [R8] host never writes one into reserved bit 2; it stays zero.
// [R9] two-bit edge rate: 00 fastest, then +50, +100, +120 ps.
// [R10] detect enabled: data terminations only after valid clock on selected port.
// [R11] detect disabled: data terminations connected whenever the port is selected.
// [R12] manual field enables exactly one port, all others disabled.
// [R13] ddc offset code: 00 range 2, 01 range 3, 11 range 1.
// [R14] status: active port 6:5, valid clock 4, cable power 3:0.
// [R15] with detection disabled the valid clock bit reads one.
// [R16] any status change raises irq, held until the host reads status.
module video_switch_control_regs
	import video_switch_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// clock and reset
	input  logic                 clock_i,
	input  logic                 sys_rst_i,
	// host serial port
	input  logic                 scl_i,
	input  logic                 sda_i,
	output logic                 sda_o,
	output logic                 sda_oe_o,
	input  logic                 local_addr_sel_i,
	output logic                 irq_o,
	// port sensing
	input  logic [NUM_PORTS-1:0] cable_power_sense_i,
	input  logic [NUM_PORTS-1:0] port_clock_valid_i,
	// switch controls
	output logic [NUM_PORTS-1:0] port_enable_o,
	output logic [NUM_PORTS-1:0] data_term_enable_o,
	output logic                 tmds_out_enable_o,
	output logic                 standby_o,
	output logic                 deep_sleep_state_o,
	output logic [1:0]           edge_rate_o,
	output logic [1:0]           ddc_offset_range_select_o,
	output logic [1:0]           ddc_offset_range_o
);

	reg_req_t              req;
	logic [7:0]            rdata;
	logic [NUM_PORTS-1:0]  pwr_s1_q, pwr_s2_q, clk_s1_q, clk_s2_q;
	cfg_power_t            cfg_power_q, cfg_power_d;
	cfg_detect_t           cfg_detect_q, cfg_detect_d;
	status_t               status_q, status_d;
	logic [1:0]            active_q, active_d;
	logic                  irq_q, irq_d;
	logic [NUM_PORTS-1:0]  port_en_q, port_en_d, term_q, term_d;
	logic                  out_en_q, out_en_d, standby_q, standby_d, sleep_q, sleep_d;
	logic [1:0]            edge_q, edge_d, ovs_q, ovs_d, range_q, range_d;
	logic                  clk_valid, normal_mode, status_read;

	function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [1:0] idx);
		port_onehot      = '0;
		port_onehot[idx] = 1'b1;
	endfunction : port_onehot

	i2c_target_port u_i2c (
		.clock_i          (clock_i),
		.sys_rst_i        (sys_rst_i),
		.scl_i            (scl_i),
		.sda_i            (sda_i),
		.sda_o            (sda_o),
		.sda_oe_o         (sda_oe_o),
		.local_addr_sel_i (local_addr_sel_i),
		.req_o            (req),
		.rdata_i          (rdata)
	);

	// register read mux
	always_comb begin
		case (req.addr)
			`REG_STATUS_OFS:     rdata = status_q; // see [R2]
			`REG_CFG_POWER_OFS:  rdata = cfg_power_q;
			`REG_CFG_DETECT_OFS: rdata = cfg_detect_q;
			default:             rdata = 8'h00;
		endcase
	end

	assign status_read = req.rd_done && (req.addr == `REG_STATUS_OFS);

	// configuration registers
	always_comb begin
		cfg_power_d  = cfg_power_q;
		cfg_detect_d = cfg_detect_q;
		if (req.wr && req.addr == `REG_CFG_POWER_OFS) begin
			cfg_power_d = req.wdata & `CFG_POWER_WMASK; // see [R8]
		end
		if (req.wr && req.addr == `REG_CFG_DETECT_OFS) begin
			cfg_detect_d = req.wdata & `CFG_DETECT_WMASK;
		end
	end

	// port choice and status
	always_comb begin
		active_d = active_q;
		if (cfg_power_q.auto_sel) begin
			if (pwr_s2_q[cfg_power_q.priority_port]) begin
				active_d = cfg_power_q.priority_port; // see [R4] see [R7]
			end else begin
				for (int i = NUM_PORTS - 1; i >= 0; i--) begin
					if (pwr_s2_q[i]) begin
						active_d = 2'(i); // see [R4]
					end
				end
			end
		end else begin
			active_d = cfg_detect_q.manual_port; // see [R5]
		end
		clk_valid                  = cfg_detect_q.clk_det_off | clk_s2_q[active_q]; // see [R15]
		status_d.rsvd              = 1'b0;
		status_d.active_port       = active_q; // see [R14]
		status_d.clk_valid         = clk_valid;
		status_d.cable_power_sense = pwr_s2_q;
		// set wins over a read that completes in the same cycle
		irq_d = (status_d != status_q) | (irq_q & ~status_read); // see [R16] see [R1]
	end

	// switch controls
	always_comb begin
		normal_mode = (cfg_power_q.power_mode == `PWR_MODE_NORMAL); // see [R3]
		standby_d   = (cfg_power_q.power_mode == `PWR_MODE_STANDBY);
		sleep_d     = cfg_power_q.power_mode[1];
		port_en_d   = normal_mode ? port_onehot(active_q) : '0; // see [R12]
		term_d      = (clk_valid) ? port_en_d : '0; // see [R10] see [R11]
		out_en_d    = normal_mode & clk_valid;
		edge_d      = cfg_power_q.edge_rate; // see [R9]
		ovs_d       = cfg_detect_q.ddc_offset_range_select;
		case (cfg_detect_q.ddc_offset_range_select)
			`DDC_CODE_RANGE1: range_d = `DDC_RANGE_1; // see [R13]
			`DDC_CODE_RANGE3: range_d = `DDC_RANGE_3;
			default:          range_d = `DDC_RANGE_2;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			pwr_s1_q     <= '0;
			pwr_s2_q     <= '0;
			clk_s1_q     <= '0;
			clk_s2_q     <= '0;
			cfg_power_q  <= `CFG_POWER_RST;
			cfg_detect_q <= `CFG_DETECT_RST;
			status_q     <= '0;
			active_q     <= 2'd0;
			irq_q        <= 1'b0;
			port_en_q    <= '0;
			term_q       <= '0;
			out_en_q     <= 1'b0;
			standby_q    <= 1'b0;
			sleep_q      <= 1'b0;
			edge_q       <= 2'd0;
			ovs_q        <= `DDC_CODE_RANGE3;
			range_q      <= `DDC_RANGE_3;
		end else begin
			pwr_s1_q     <= cable_power_sense_i;
			pwr_s2_q     <= pwr_s1_q;
			clk_s1_q     <= port_clock_valid_i;
			clk_s2_q     <= clk_s1_q;
			cfg_power_q  <= cfg_power_d;
			cfg_detect_q <= cfg_detect_d;
			status_q     <= status_d;
			active_q     <= active_d;
			irq_q        <= irq_d;
			port_en_q    <= port_en_d;
			term_q       <= term_d;
			out_en_q     <= out_en_d;
			standby_q    <= standby_d;
			sleep_q      <= sleep_d;
			edge_q       <= edge_d;
			ovs_q        <= ovs_d;
			range_q      <= range_d;
		end
	end

	assign irq_o                     = irq_q;
	assign port_enable_o             = port_en_q;
	assign data_term_enable_o        = term_q;
	assign tmds_out_enable_o         = out_en_q;
	assign standby_o                 = standby_q;
	assign deep_sleep_state_o        = sleep_q;
	assign edge_rate_o               = edge_q;
	assign ddc_offset_range_select_o = ovs_q;
	assign ddc_offset_range_o        = range_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	sequence status_read_s;
		status_read && (status_d == status_q);
	endsequence

	sequence status_change_s;
		status_d != status_q;
	endsequence

	irq_clear_a: assert property (status_read_s |=> !irq_o) // see [R1]
		else $error("irq still high after status read");
	irq_set_a: assert property (status_change_s |=> irq_o ##1 (irq_o || $past(status_read))) // see [R16]
		else $error("irq not raised or dropped without read");
	status_live_a: assert property (1'b1 |=> status_q == $past(status_d)) // see [R2]
		else $error("status not following live state");
	status_layout_a: assert property (1'b1 |=> status_q[6:5] == $past(active_q) && !status_q[7]) // see [R14]
		else $error("status active port field wrong");
	clk_forced_a: assert property (cfg_detect_q.clk_det_off |=> status_q.clk_valid) // see [R15]
		else $error("valid clock bit not forced high");
	power_mode_a: assert property (cfg_power_q.power_mode[1] |=> deep_sleep_state_o && !standby_o
		&& port_enable_o == '0) // see [R3]
		else $error("deep sleep mode decode wrong");
	manual_port_a: assert property (!cfg_power_q.auto_sel |=> active_q == $past(cfg_detect_q.manual_port)) // see [R5]
		else $error("manual port not taken");
	auto_prio_a: assert property (cfg_power_q.auto_sel && pwr_s2_q[cfg_power_q.priority_port]
		|=> active_q == $past(cfg_power_q.priority_port)) // see [R4]
		else $error("powered priority port not chosen");
	port_onehot_a: assert property ($onehot0(port_enable_o)) // see [R12]
		else $error("more than one port enabled");
	term_gate_a: assert property (!cfg_detect_q.clk_det_off && !clk_s2_q[active_q]
		|=> data_term_enable_o == '0) // see [R10]
		else $error("data termination without valid clock");
	term_always_a: assert property (cfg_detect_q.clk_det_off |=> data_term_enable_o == port_enable_o) // see [R11]
		else $error("termination not tied to selection");
	edge_rate_a: assert property ($changed(cfg_power_q.edge_rate) |=> edge_rate_o == $past(cfg_power_q.edge_rate)) // see [R9]
		else $error("edge rate not applied");
	ddc_range_a: assert property (cfg_detect_q.ddc_offset_range_select == `DDC_CODE_RANGE1
		|=> ddc_offset_range_o == `DDC_RANGE_1) // see [R13]
		else $error("ddc range decode wrong");
	rsvd_zero_a: assert property (1'b1 |-> !cfg_power_q.rsvd && cfg_detect_q.rsvd == 3'd0) // see [R8]
		else $error("reserved configuration bit set");

endmodule : video_switch_control_regs

// ---- src/video_switch_cfg.svh ----
`ifndef VIDEO_SWITCH_CFG_SVH
`define VIDEO_SWITCH_CFG_SVH

// register offsets
`define REG_STATUS_OFS     8'h01
`define REG_CFG_POWER_OFS  8'h02
`define REG_CFG_DETECT_OFS 8'h03

// reset values
`define CFG_POWER_RST      8'h00
`define CFG_DETECT_RST     8'h08

// writable bits of the power and selection register, reserved bit 2 held at zero
`define CFG_POWER_WMASK    8'hfb
// writable bits of the detect register, bits 2:0 reserved
`define CFG_DETECT_WMASK   8'hf8

// seven-bit target address with the strap bit cleared
`define I2C_BASE_ADDR      7'h2c

// field codes
`define PWR_MODE_NORMAL    2'b00
`define PWR_MODE_STANDBY   2'b01
`define DDC_CODE_RANGE2    2'b00
`define DDC_CODE_RANGE3    2'b01
`define DDC_CODE_RANGE1    2'b11
`define DDC_RANGE_1        2'd1
`define DDC_RANGE_2        2'd2
`define DDC_RANGE_3        2'd3

`endif

// ---- src/video_switch_pkg.sv ----
package video_switch_pkg;

	typedef struct packed {
		logic       rsvd;
		logic [1:0] active_port;
		logic       clk_valid;
		logic [3:0] cable_power_sense;
	} status_t;

	typedef struct packed {
		logic [1:0] power_mode;
		logic       auto_sel;
		logic [1:0] priority_port;
		logic       rsvd;
		logic [1:0] edge_rate;
	} cfg_power_t;

	typedef struct packed {
		logic       clk_det_off;
		logic [1:0] manual_port;
		logic [1:0] ddc_offset_range_select;
		logic [2:0] rsvd;
	} cfg_detect_t;

	// register access from the serial port
	typedef struct packed {
		logic       wr;
		logic       rd_done;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [3:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR_ACK,
		I2C_SUB,
		I2C_SUB_ACK,
		I2C_WDATA,
		I2C_WACK,
		I2C_RDATA,
		I2C_RACK
	} i2c_state_t;

endpackage : video_switch_pkg

// ---- src/i2c_target_port.sv ----
`timescale 1ns/1ps
`include "video_switch_cfg.svh"

module i2c_target_port
	import video_switch_pkg::*;
(
	// clock and reset
	input  logic       clock_i,
	input  logic       sys_rst_i,
	// serial pins
	input  logic       scl_i,
	input  logic       sda_i,
	output logic       sda_o,
	output logic       sda_oe_o,
	input  logic       local_addr_sel_i,
	// register side
	output reg_req_t   req_o,
	input  logic [7:0] rdata_i
);

	logic [2:0]  sync1_q, sync2_q;
	logic        scl_prev_q, sda_prev_q;
	i2c_state_t  state_q, state_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  tx_q, tx_d;
	logic [7:0]  ptr_q, ptr_d;
	logic        rw_q, rw_d;
	logic        ack_q, ack_d;
	logic        oe_q, oe_d;
	reg_req_t    req_q, req_d;
	logic        scl_s, sda_s, rise, fall, start_c, stop_c;

	assign scl_s    = sync2_q[0];
	assign sda_s    = sync2_q[1];
	assign rise     = scl_s & ~scl_prev_q;
	assign fall     = ~scl_s & scl_prev_q;
	assign start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign sda_o    = 1'b0;
	assign sda_oe_o = oe_q;
	assign req_o    = req_q;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		ack_d   = ack_q;
		oe_d    = oe_q;
		req_d   = '0;
		req_d.addr  = ptr_q;
		req_d.wdata = sh_q;
		if (start_c) begin
			state_d = I2C_ADDR;
			cnt_d   = 4'd0;
			oe_d    = 1'b0;
		end else if (stop_c) begin
			state_d = I2C_IDLE;
			oe_d    = 1'b0;
		end else if (rise) begin
			case (state_q)
				I2C_ADDR, I2C_SUB, I2C_WDATA: begin
					sh_d  = {sh_q[6:0], sda_s};
					cnt_d = cnt_q + 4'd1;
				end
				I2C_RDATA: cnt_d = cnt_q + 4'd1;
				I2C_RACK: begin
					// completed byte reported with the old pointer in the same cycle the pointer moves on
					ack_d         = ~sda_s;
					req_d.rd_done = 1'b1;
					ptr_d         = ptr_q + 8'd1;
				end
				default: ;
			endcase
		end else if (fall) begin
			case (state_q)
				I2C_ADDR: if (cnt_q == 4'd8) begin
					if (sh_q[7:1] == (`I2C_BASE_ADDR | {6'd0, sync2_q[2]})) begin
						rw_d    = sh_q[0];
						oe_d    = 1'b1;
						state_d = I2C_ADDR_ACK;
					end else begin
						state_d = I2C_IDLE;
					end
				end
				I2C_ADDR_ACK: begin
					cnt_d = 4'd0;
					if (rw_q) begin
						tx_d    = rdata_i;
						oe_d    = ~rdata_i[7];
						state_d = I2C_RDATA;
					end else begin
						oe_d    = 1'b0;
						state_d = I2C_SUB;
					end
				end
				I2C_SUB: if (cnt_q == 4'd8) begin
					ptr_d   = sh_q;
					oe_d    = 1'b1;
					state_d = I2C_SUB_ACK;
				end
				I2C_SUB_ACK, I2C_WACK: begin
					oe_d    = 1'b0;
					cnt_d   = 4'd0;
					state_d = I2C_WDATA;
				end
				I2C_WDATA: if (cnt_q == 4'd8) begin
					req_d.wr = 1'b1;
					oe_d     = 1'b1;
					state_d  = I2C_WACK;
				end
				I2C_RDATA: begin
					if (cnt_q == 4'd8) begin
						oe_d    = 1'b0;
						state_d = I2C_RACK;
					end else begin
						tx_d = {tx_q[6:0], 1'b0};
						oe_d = ~tx_q[6];
					end
				end
				I2C_RACK: begin
					cnt_d = 4'd0;
					if (ack_q) begin
						tx_d    = rdata_i;
						oe_d    = ~rdata_i[7];
						state_d = I2C_RDATA;
					end else begin
						state_d = I2C_IDLE;
					end
				end
				default: state_d = I2C_IDLE;
			endcase
		end
		if (state_q == I2C_WACK && fall) begin
			ptr_d = ptr_q + 8'd1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sync1_q    <= 3'b011;
			sync2_q    <= 3'b011;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			state_q    <= I2C_IDLE;
			cnt_q      <= 4'd0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			ptr_q      <= 8'h00;
			rw_q       <= 1'b0;
			ack_q      <= 1'b0;
			oe_q       <= 1'b0;
			req_q      <= '0;
		end else begin
			sync1_q    <= {local_addr_sel_i, sda_i, scl_i};
			sync2_q    <= sync1_q;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			tx_q       <= tx_d;
			ptr_q      <= ptr_d;
			rw_q       <= rw_d;
			ack_q      <= ack_d;
			oe_q       <= oe_d;
			req_q      <= req_d;
		end
	end

endmodule : i2c_target_port

// ---- tb/i2c_host_model.sv ----
`timescale 1ns/1ps

// sink microcontroller as i2c master; scl idles high between frames
module i2c_host_model (
	// clock
	input  wire logic clock_i,
	// serial pins
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask : tick

	// one bit, about 65 ns; sda moves only while scl is low
	task automatic bit_io(input logic b, output logic s);
		tick(3);
		sda_low_o = ~b;
		tick(4);
		scl_o = 1'b1;
		tick(5);
		s = sda_i;
		tick(1);
		scl_o = 1'b0;
	endtask : bit_io

	task automatic start();
		if (scl_o === 1'b0) begin
			tick(3);
			sda_low_o = 1'b0;
			tick(4);
			scl_o = 1'b1;
			tick(4);
		end
		sda_low_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
	endtask : start

	task automatic stop();
		tick(3);
		sda_low_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		sda_low_o = 1'b0;
		tick(8);
	endtask : stop

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : send_byte

	// last byte answered with nack
	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(last, s);
	endtask : recv_byte

	task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs,
		input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte({a, 1'b0}, a0);
		send_byte(ofs, a1);
		send_byte(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : write_reg

	task automatic read_reg(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d);
		logic k;
		start();
		send_byte({a, 1'b0}, k);
		send_byte(ofs, k);
		start();
		send_byte({a, 1'b1}, k);
		recv_byte(1'b1, d);
		stop();
	endtask : read_reg
endmodule : i2c_host_model

// ---- tb/test_video_switch_control_regs.sv ----
`timescale 1ns/1ps
`include "video_switch_cfg.svh"

module test_video_switch_control_regs;
	logic       clock_i;
	logic       sys_rst_i;
	logic [3:0] cable, clk_ok, port_en, term_en;
	logic       scl, sda, sda_low, sda_o, sda_oe, irq, out_en, standby, deep;
	logic [1:0] edge_rate, ddc_sel, ddc_rng;
	int         n_mismatch;
	int         checked;

	// open-drain wire with pull-up
	assign sda = ~(sda_low | (sda_oe & ~sda_o));

	i2c_host_model i_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

	video_switch_control_regs #(.NUM_PORTS(4)) i_dut (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .local_addr_sel_i(1'b0), .irq_o(irq),
		.cable_power_sense_i(cable), .port_clock_valid_i(clk_ok),
		.port_enable_o(port_en), .data_term_enable_o(term_en),
		.tmds_out_enable_o(out_en), .standby_o(standby), .deep_sleep_state_o(deep),
		.edge_rate_o(edge_rate), .ddc_offset_range_select_o(ddc_sel),
		.ddc_offset_range_o(ddc_rng));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask : tick

	task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
		logic ok;
		i_host.write_reg(`I2C_BASE_ADDR, ofs, d, ok);
		check("write ack", {7'h0, ok}, 8'h01);
		tick(4);
	endtask : wreg

	task automatic rreg(input logic [7:0] ofs, input logic [7:0] e, input string name);
		logic [7:0] d;
		i_host.read_reg(`I2C_BASE_ADDR, ofs, d);
		check(name, d, e);
	endtask : rreg

	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (irq !== lvl && n < 50) begin
			tick(1);
			n++;
		end
		if (irq !== lvl) begin
			n_mismatch++;
			conclude();
		end
	endtask : wait_irq

	task automatic t_reset();
		logic ok;
		rreg(`REG_CFG_POWER_OFS, `CFG_POWER_RST, "cfg power");
		rreg(`REG_CFG_DETECT_OFS, `CFG_DETECT_RST, "cfg detect");
		rreg(8'h05, 8'h00, "unmapped");
		rreg(`REG_STATUS_OFS, 8'h00, "status");
		check("port enable", 8'(port_en), 8'h01);
		check("ddc range", 8'(ddc_rng), 8'h03);
		i_host.write_reg(7'h2d, `REG_CFG_POWER_OFS, 8'h01, ok);
		check("foreign ack", {7'h0, ok}, 8'h00);
		wreg(`REG_STATUS_OFS, 8'hff);
		rreg(`REG_CFG_POWER_OFS, 8'h00, "cfg power kept");
		rreg(`REG_STATUS_OFS, 8'h00, "status read only");
		$display("test reset done");
	endtask : t_reset

	task automatic t_manual();
		logic [1:0] p;
		clk_ok = 4'hf;
		tick(10);
		for (int i = 0; i < 4; i++) begin
			p = 2'(i);
			wreg(`REG_CFG_DETECT_OFS, {1'b0, p, 2'b01, 3'b000});
			check("port enable", 8'(port_en), 8'(4'b0001 << i));
			check("terminations", 8'(term_en), 8'(4'b0001 << i));
			rreg(`REG_STATUS_OFS, {1'b0, p, 1'b1, 4'h0}, "status port");
		end
		$display("test manual done");
	endtask : t_manual

	task automatic t_detect();
		wreg(`REG_CFG_DETECT_OFS, 8'h28);
		clk_ok = 4'b1101;
		tick(10);
		check("terminations", 8'(term_en), 8'h00);
		check("output enable", {7'h0, out_en}, 8'h00);
		rreg(`REG_STATUS_OFS, 8'h20, "status no clock");
		wreg(`REG_CFG_DETECT_OFS, 8'ha8);
		check("terminations", 8'(term_en), 8'h02);
		check("output enable", {7'h0, out_en}, 8'h01);
		rreg(`REG_STATUS_OFS, 8'h30, "status forced clock");
		clk_ok = 4'hf;
		$display("test detect done");
	endtask : t_detect

	task automatic t_auto();
		logic [1:0] q;
		wreg(`REG_CFG_DETECT_OFS, 8'h08);
		cable = 4'hf;
		tick(10);
		for (int i = 0; i < 4; i++) begin
			q = 2'(i);
			// reserved bit 2 always written as zero
			wreg(`REG_CFG_POWER_OFS, {3'b001, q, 3'b000});
			rreg(`REG_STATUS_OFS, {1'b0, q, 1'b1, 4'hf}, "auto priority");
		end
		cable = 4'hc;
		wreg(`REG_CFG_POWER_OFS, 8'h20);
		rreg(`REG_STATUS_OFS, 8'h5c, "auto fallback");
		check("port enable", 8'(port_en), 8'h04);
		wreg(`REG_CFG_POWER_OFS, 8'h00);
		rreg(`REG_STATUS_OFS, 8'h1c, "auto off");
		$display("test auto done");
	endtask : t_auto

	task automatic t_power_edge();
		logic [1:0] m;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			v = {m, 4'b0000, m};
			wreg(`REG_CFG_POWER_OFS, v);
			check("standby", {7'h0, standby}, {7'h0, m == 2'b01});
			check("deep sleep", {7'h0, deep}, {7'h0, m[1]});
			check("port enable", 8'(port_en), {7'h0, m == 2'b00});
			check("edge rate", 8'(edge_rate), 8'(m));
			rreg(`REG_CFG_POWER_OFS, v, "cfg power back");
		end
		wreg(`REG_CFG_POWER_OFS, 8'h00);
		$display("test power and edge done");
	endtask : t_power_edge

	task automatic t_ddc();
		logic [1:0] codes [3];
		logic [1:0] rngs [3];
		codes = '{2'b00, 2'b01, 2'b11};
		rngs = '{2'd2, 2'd3, 2'd1};
		for (int i = 0; i < 3; i++) begin
			wreg(`REG_CFG_DETECT_OFS, {3'b000, codes[i], 3'b000});
			check("ddc select", 8'(ddc_sel), 8'(codes[i]));
			check("ddc range", 8'(ddc_rng), 8'(rngs[i]));
			rreg(`REG_CFG_DETECT_OFS, {3'b000, codes[i], 3'b000}, "cfg detect back");
		end
		$display("test ddc done");
	endtask : t_ddc

	task automatic t_irq();
		rreg(`REG_STATUS_OFS, 8'h1c, "status");
		check("irq idle", {7'h0, irq}, 8'h00);
		cable = 4'hd;
		wait_irq(1'b1);
		tick(30);
		check("irq held", {7'h0, irq}, 8'h01);
		rreg(`REG_STATUS_OFS, 8'h1d, "status live");
		check("irq cleared", {7'h0, irq}, 8'h00);
		clk_ok = 4'he;
		wait_irq(1'b1);
		rreg(`REG_STATUS_OFS, 8'h0d, "status clock lost");
		check("irq cleared", {7'h0, irq}, 8'h00);
		$display("test irq done");
	endtask : t_irq

	initial begin
		sys_rst_i = 1'b1;
		cable = 4'h0;
		clk_ok = 4'h0;
		n_mismatch = 0;
		checked = 0;
		tick(20);
		sys_rst_i = 1'b0;
		tick(8);
		t_reset();
		t_manual();
		t_detect();
		t_auto();
		t_power_edge();
		t_ddc();
		t_irq();
		conclude();
	end
endmodule : test_video_switch_control_regs
